// ### src/clock_prescaler_consts.svh
// Register offsets, field positions, reset values and codes of the clock prescaler block
`ifndef CLOCK_PRESCALER_CONSTS_SVH
`define CLOCK_PRESCALER_CONSTS_SVH

`define OFS_SYSDIV 8'h00
`define OFS_SLOWDIV 8'h04
`define OFS_AUXDIV 8'h08
`define OFS_CLKCTRL 8'h0c
`define OFS_PWRCTRL 8'h10
`define OFS_STATUS 8'h14

`define RST_SYSDIV 8'h4f
`define RST_SLOWDIV 8'hb6
`define RST_AUXDIV 8'hff
`define RST_CLKCTRL 6'h06
`define RST_PWRCTRL 5'h00

`define SYSDIV_DIV_LSB 0
`define SYSDIV_DIV_MSB 3
`define SYSDIV_MODE_LSB 4
`define SYSDIV_MODE_MSB 6
`define AUX_ONE_LSB 0
`define AUX_ONE_MSB 3
`define AUX_TWO_LSB 4
`define AUX_TWO_MSB 7

`define PLL_MODE_X3 3'h3
`define PLL_MODE_X4 3'h4
`define PLL_MODE_X5 3'h5

`define CC_SLOW_LFO 0
`define CC_FAST_SEL 1
`define CC_PLL_PWD 2
`define CC_AUX1_EN 3
`define CC_AUX2_EN 4
`define CC_RNG_EN 5
`define CC_WIDTH 6

`define PC_PSM 0
`define PC_IDLE 1
`define PC_HALT 2
`define PC_WBPSM 3
`define PC_DMC 4
`define PC_WIDTH 5

`define ST_MODE_LSB 0
`define ST_MODE_MSB 1
`define ST_STALL 2
`define ST_MODE_OK 3
`define ST_SLOW_LFO 4
`define ST_HFO_ON 5

`endif

// ### src/clock_prescaler_pkg.sv
// Types shared by the clock prescaler and power mode block
package clock_prescaler_pkg;
   typedef enum logic [1:0] {
      mode_active = 2'b00,
      mode_power_save = 2'b01,
      mode_idle = 2'b10,
      mode_halt = 2'b11
   } power_mode_t;
endpackage

// ### src/clock_prescaler_power_modes.sv
// Clock dividers and power mode manager with an APB register slave
//
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/1ns
`include "clock_prescaler_consts.svh"

// Function
// - System clock equals source divided by divisor plus one
// - System divider register resets 4Fh unless programming mode
// - PLL mode codes 3,4,5 give x3,x4,x5
// - PLL mode field resets to 100b
// - Slow clock is main divided by 2(n+1)
// - Slow divider register resets to B6h
// - Aux clock one is main over divisor plus one
// - Aux clock two is main over divisor plus one
// - Aux divider register resets to FFh
// - Four power modes, Active after reset
// - System and timer clock source per mode
// - Halt stops oscillator and slow clock, LFO runs
// - Outside Halt, oscillator off only when slow clock uses LFO
// - CPU runs per mode; wakeup logic keeps working
// - Fast peripherals stop in Halt, others in Idle
// - ADC clock stopped in Halt, not disabled
// - RNG oscillators independent of system clocks
// - Active system clock is divided PLL or main
// - Wait stalls CPU until an interrupt arrives
// - Slow clock from LFO or divided main clock
// - Fast select 0 picks PLL, 1 main, default
module clock_prescaler_power_modes #(
   parameter logic [7:0] programming_mode_sysdiv_reset = 8'h40
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic programming_mode,
   input wire logic main_tick,
   input wire logic pll_tick,
   input wire logic pll_locked,
   input wire logic lfo_tick,
   input wire logic lfo_running,
   input wire logic hfo_stable,
   input wire logic wait_exec,
   input wire logic interrupt_req,
   input wire logic wakeup_event,
   output logic sys_clk_en,
   output logic slow_clk_en,
   output logic timer_clk_en,
   output logic aux1_clk_en,
   output logic aux2_clk_en,
   output logic hfo_enable,
   output logic pll_enable,
   output logic [2:0] pll_mode,
   output logic cpu_run,
   output logic fast_periph_clk_on,
   output logic other_periph_clk_on,
   output logic rng_osc_enable,
   output logic [1:0] power_mode
);

   logic [7:0] sysdiv_reg;
   logic [7:0] slowdiv_reg;
   logic [7:0] auxdiv_reg;
   logic [`CC_WIDTH-1:0] clkctrl_reg;
   logic [`PC_WIDTH-1:0] pwrctrl_reg;
   logic strap_done_reg;
   clock_prescaler_pkg::power_mode_t mode_reg;
   clock_prescaler_pkg::power_mode_t mode_next;
   logic waking_reg;
   logic stall_reg;
   logic hfo_on_reg;
   logic wr_en;
   logic rd_en;
   logic addr_ok;
   logic slow_from_lfo;
   logic main_live;
   logic mode_ok;
   logic [7:0] wbyte;
   logic [3:0] src_en;
   logic [3:0] run;
   logic [3:0] tick;
   logic [8:0] div_val [0:3];
   logic [8:0] cnt_reg [0:3];
   logic [31:0] rd_mux;

   // One wait state keeps pready and prdata straight from flip-flops
   assign wr_en = psel && penable && pready && pwrite;
   assign rd_en = psel && penable && !pready && !pwrite;
   assign wbyte = pstrb[0] ? pwdata[7:0] : 8'h00;

   always_comb begin
      addr_ok = 1'b1;
      if (paddr == `OFS_SYSDIV) begin
         rd_mux = {24'h000000, sysdiv_reg};
      end else if (paddr == `OFS_SLOWDIV) begin
         rd_mux = {24'h000000, slowdiv_reg};
      end else if (paddr == `OFS_AUXDIV) begin
         rd_mux = {24'h000000, auxdiv_reg};
      end else if (paddr == `OFS_CLKCTRL) begin
         rd_mux = {26'h0000000, clkctrl_reg};
      end else if (paddr == `OFS_PWRCTRL) begin
         rd_mux = {27'h0000000, pwrctrl_reg};
      end else if (paddr == `OFS_STATUS) begin
         rd_mux = {26'h0000000, hfo_on_reg, slow_from_lfo, mode_ok, stall_reg,
                   mode_reg};
      end else begin
         rd_mux = 32'h00000000;
         addr_ok = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && !addr_ok;
         if (rd_en) begin
            prdata <= rd_mux;
         end
      end
   end

   // Strap is caught on the first edge after reset release
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strap_done_reg <= 1'b0;
         sysdiv_reg <= `RST_SYSDIV;
      end else begin
         strap_done_reg <= 1'b1;
         if (!strap_done_reg && programming_mode) begin
            sysdiv_reg <= programming_mode_sysdiv_reset;
         end else if (wr_en && paddr == `OFS_SYSDIV && pstrb[0]) begin
            sysdiv_reg <= {1'b0, wbyte[6:0]};
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slowdiv_reg <= `RST_SLOWDIV;
         auxdiv_reg <= `RST_AUXDIV;
      end else if (wr_en && pstrb[0]) begin
         if (paddr == `OFS_SLOWDIV) begin
            slowdiv_reg <= wbyte;
         end else if (paddr == `OFS_AUXDIV) begin
            auxdiv_reg <= wbyte;
         end
      end
   end

   // Clock control: PLL may only be selected when powered and locked,
   // and it may only be powered down while the main clock is selected
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clkctrl_reg <= `RST_CLKCTRL;
      end else if (wr_en && paddr == `OFS_CLKCTRL && pstrb[0]) begin
         clkctrl_reg[`CC_SLOW_LFO] <= wbyte[`CC_SLOW_LFO];
         clkctrl_reg[`CC_AUX1_EN] <= wbyte[`CC_AUX1_EN];
         clkctrl_reg[`CC_AUX2_EN] <= wbyte[`CC_AUX2_EN];
         clkctrl_reg[`CC_RNG_EN] <= wbyte[`CC_RNG_EN];
         if (wbyte[`CC_FAST_SEL] ||
             (!clkctrl_reg[`CC_PLL_PWD] && pll_locked)) begin
            clkctrl_reg[`CC_FAST_SEL] <= wbyte[`CC_FAST_SEL];
         end
         if (!wbyte[`CC_PLL_PWD] || clkctrl_reg[`CC_FAST_SEL]) begin
            clkctrl_reg[`CC_PLL_PWD] <= wbyte[`CC_PLL_PWD];
         end
      end
   end

   // Request bits: software write wins over a same-cycle hardware clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwrctrl_reg <= `RST_PWRCTRL;
      end else if (wr_en && paddr == `OFS_PWRCTRL && pstrb[0]) begin
         pwrctrl_reg <= wbyte[`PC_WIDTH-1:0];
      end else if (wakeup_event && mode_reg != clock_prescaler_pkg::mode_halt) begin
         pwrctrl_reg[`PC_PSM] <= 1'b0;
         pwrctrl_reg[`PC_IDLE] <= 1'b0;
         pwrctrl_reg[`PC_DMC] <= 1'b0;
      end else if (mode_reg == clock_prescaler_pkg::mode_halt &&
                   mode_next == clock_prescaler_pkg::mode_active) begin
         pwrctrl_reg[`PC_HALT] <= 1'b0;
         pwrctrl_reg[`PC_DMC] <= 1'b0;
      end
   end

   // Power mode sequencing
   always_comb begin
      mode_next = mode_reg;
      case (mode_reg)
         clock_prescaler_pkg::mode_active: begin
            if (pwrctrl_reg[`PC_WBPSM]) begin
               if (wait_exec && pwrctrl_reg[`PC_HALT]) begin
                  mode_next = clock_prescaler_pkg::mode_halt;
               end else if (wait_exec && pwrctrl_reg[`PC_IDLE]) begin
                  mode_next = clock_prescaler_pkg::mode_idle;
               end else if (wait_exec && pwrctrl_reg[`PC_PSM]) begin
                  mode_next = clock_prescaler_pkg::mode_power_save;
               end
            end else if (pwrctrl_reg[`PC_PSM]) begin
               mode_next = clock_prescaler_pkg::mode_power_save;
            end
         end
         clock_prescaler_pkg::mode_power_save: begin
            if (wakeup_event || !pwrctrl_reg[`PC_PSM]) begin
               mode_next = clock_prescaler_pkg::mode_active;
            end
         end
         clock_prescaler_pkg::mode_idle: begin
            if (wakeup_event || !pwrctrl_reg[`PC_IDLE]) begin
               mode_next = clock_prescaler_pkg::mode_active;
            end
         end
         clock_prescaler_pkg::mode_halt: begin
            // Leave only once the restarted oscillator is stable
            if (waking_reg && hfo_stable) begin
               mode_next = clock_prescaler_pkg::mode_active;
            end
         end
         default: begin
            mode_next = clock_prescaler_pkg::mode_active;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_reg <= clock_prescaler_pkg::mode_active;
      end else begin
         mode_reg <= mode_next;
      end
   end

   // Wakeup is seen on pclk, which never stops here
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         waking_reg <= 1'b0;
      end else if (mode_reg != clock_prescaler_pkg::mode_halt) begin
         waking_reg <= 1'b0;
      end else if (wakeup_event) begin
         waking_reg <= 1'b1;
      end
   end

   // Interrupt wins over a wait in the same cycle, so none is lost
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stall_reg <= 1'b0;
      end else if (interrupt_req) begin
         stall_reg <= 1'b0;
      end else if (wait_exec) begin
         stall_reg <= 1'b1;
      end
   end

   // Oscillator may drop in Power Save or Idle only with the slow clock on the LFO
   assign slow_from_lfo = clkctrl_reg[`CC_SLOW_LFO] && lfo_running;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hfo_on_reg <= 1'b1;
      end else if (mode_next == clock_prescaler_pkg::mode_active) begin
         hfo_on_reg <= 1'b1;
      end else if (mode_next == clock_prescaler_pkg::mode_halt) begin
         hfo_on_reg <= waking_reg || wakeup_event;
      end else begin
         hfo_on_reg <= !(pwrctrl_reg[`PC_DMC] && slow_from_lfo);
      end
   end

   assign main_live = main_tick && hfo_on_reg;
   assign mode_ok = sysdiv_reg[`SYSDIV_MODE_MSB:`SYSDIV_MODE_LSB] == `PLL_MODE_X3 ||
                    sysdiv_reg[`SYSDIV_MODE_MSB:`SYSDIV_MODE_LSB] == `PLL_MODE_X4 ||
                    sysdiv_reg[`SYSDIV_MODE_MSB:`SYSDIV_MODE_LSB] == `PLL_MODE_X5;

   // Divider sources: 0 system, 1 slow, 2 aux one, 3 aux two
   always_comb begin
      src_en[0] = clkctrl_reg[`CC_FAST_SEL] ? main_live : pll_tick;
      src_en[1] = main_live;
      src_en[2] = main_live;
      src_en[3] = main_live;
      run[0] = 1'b1;
      run[1] = mode_reg != clock_prescaler_pkg::mode_halt;
      run[2] = clkctrl_reg[`CC_AUX1_EN] && mode_reg != clock_prescaler_pkg::mode_halt;
      run[3] = clkctrl_reg[`CC_AUX2_EN] && mode_reg != clock_prescaler_pkg::mode_halt;
      div_val[0] = {5'h00, sysdiv_reg[`SYSDIV_DIV_MSB:`SYSDIV_DIV_LSB]};
      div_val[1] = {slowdiv_reg, 1'b1};
      div_val[2] = {5'h00, auxdiv_reg[`AUX_ONE_MSB:`AUX_ONE_LSB]};
      div_val[3] = {5'h00, auxdiv_reg[`AUX_TWO_MSB:`AUX_TWO_LSB]};
   end

   // Reload only at terminal count, so a write never clips a period
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_div
         assign tick[gi] = src_en[gi] && run[gi] && cnt_reg[gi] == 9'h000;
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               cnt_reg[gi] <= 9'h000;
            end else if (src_en[gi] && run[gi]) begin
               if (cnt_reg[gi] == 9'h000) begin
                  cnt_reg[gi] <= div_val[gi];
               end else begin
                  cnt_reg[gi] <= cnt_reg[gi] - 9'h001;
               end
            end
         end
      end
   endgenerate

   // Clock enables and gates, all registered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sys_clk_en <= 1'b0;
         slow_clk_en <= 1'b0;
         timer_clk_en <= 1'b0;
      end else begin
         case (mode_reg)
            clock_prescaler_pkg::mode_active: begin
               sys_clk_en <= tick[0];
            end
            clock_prescaler_pkg::mode_power_save: begin
               sys_clk_en <= slow_from_lfo ? lfo_tick : tick[1];
            end
            default: begin
               sys_clk_en <= 1'b0;
            end
         endcase
         if (mode_reg == clock_prescaler_pkg::mode_halt) begin
            slow_clk_en <= 1'b0;
            timer_clk_en <= 1'b0;
         end else begin
            slow_clk_en <= slow_from_lfo ? lfo_tick : tick[1];
            timer_clk_en <= slow_from_lfo ? lfo_tick : tick[1];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         aux1_clk_en <= 1'b0;
         aux2_clk_en <= 1'b0;
      end else begin
         aux1_clk_en <= tick[2];
         aux2_clk_en <= tick[3];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hfo_enable <= 1'b1;
         pll_enable <= 1'b0;
         pll_mode <= `PLL_MODE_X4;
         cpu_run <= 1'b1;
         fast_periph_clk_on <= 1'b1;
         other_periph_clk_on <= 1'b1;
         rng_osc_enable <= 1'b0;
         power_mode <= 2'b00;
      end else begin
         hfo_enable <= hfo_on_reg;
         pll_enable <= !clkctrl_reg[`CC_PLL_PWD] && hfo_on_reg &&
                       mode_reg != clock_prescaler_pkg::mode_halt;
         pll_mode <= sysdiv_reg[`SYSDIV_MODE_MSB:`SYSDIV_MODE_LSB];
         cpu_run <= !stall_reg && (mode_reg == clock_prescaler_pkg::mode_active ||
                    mode_reg == clock_prescaler_pkg::mode_power_save);
         // Stopped, not disabled: the converter resumes where it stood
         fast_periph_clk_on <= mode_reg != clock_prescaler_pkg::mode_halt;
         other_periph_clk_on <= mode_reg == clock_prescaler_pkg::mode_active ||
                                mode_reg == clock_prescaler_pkg::mode_power_save;
         // Independent of the power mode, so software must clear it itself
         rng_osc_enable <= clkctrl_reg[`CC_RNG_EN];
         power_mode <= mode_reg;
      end
   end

endmodule

// ### sim/prescaler_chk.sv
// Concurrent checks on the ports of the clock prescaler and power mode block
`timescale 1ns/1ns
module prescaler_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic wakeup_event,
   input wire logic sys_clk_en,
   input wire logic slow_clk_en,
   input wire logic timer_clk_en,
   input wire logic hfo_enable,
   input wire logic pll_enable,
   input wire logic [2:0] pll_mode,
   input wire logic cpu_run,
   input wire logic fast_periph_clk_on,
   input wire logic other_periph_clk_on,
   input wire logic [1:0] power_mode
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic halt_woke;
   // A wakeup in Halt restarts the oscillator before the mode output changes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         halt_woke <= 1'b0;
      end else if (power_mode != 2'h3) begin
         halt_woke <= 1'b0;
      end else if (wakeup_event) begin
         halt_woke <= 1'b1;
      end
   end
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence access_s;
      psel && penable;
   endsequence
   AST_RESET_STATE: assert property ($rose(presetn) |-> power_mode == 2'h0 && pll_mode == 3'h4
      && hfo_enable && cpu_run) else $error("state after reset wrong");
   AST_ONE_WAIT: assert property (setup_s ##1 access_s |-> !pready ##1 pready)
      else $error("answer not after one wait state");
   AST_READY_PULSE: assert property (pready |=> !pready) else $error("pready longer than one cycle");
   AST_ERR_WITH_READY: assert property (pslverr |-> pready) else $error("pslverr without pready");
   AST_HIGH_ZERO: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
      else $error("upper read bits not zero");
   // Mode output is registered in the same cycle as the gating, yet the check waits a settled cycle
   AST_HALT_GATES: assert property (power_mode == 2'h3 [*2] |-> !sys_clk_en && !slow_clk_en
      && !timer_clk_en && !cpu_run && !fast_periph_clk_on && !other_periph_clk_on)
      else $error("clock running in halt");
   AST_HALT_OSC: assert property ((power_mode == 2'h3 && !halt_woke && !wakeup_event) [*4]
      |-> !hfo_enable && !pll_enable) else $error("oscillator on in halt");
   AST_IDLE_GATES: assert property (power_mode == 2'h2 [*2] |-> !sys_clk_en && !cpu_run
      && !other_periph_clk_on) else $error("system clock running in idle");
   AST_ACTIVE_OSC: assert property (power_mode == 2'h0 [*2] |-> hfo_enable)
      else $error("oscillator off in active");
   AST_TIMER_SLOW: assert property (power_mode != 2'h3 [*2] |-> timer_clk_en == slow_clk_en)
      else $error("timer clock differs from slow clock");
   AST_WAKE_EXIT: assert property ((power_mode == 2'h1 || power_mode == 2'h2) && wakeup_event
      |-> ##[1:3] power_mode == 2'h0) else $error("no exit on wakeup");
endmodule

bind clock_prescaler_power_modes prescaler_chk chk_u (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .wakeup_event(wakeup_event), .sys_clk_en(sys_clk_en),
   .slow_clk_en(slow_clk_en), .timer_clk_en(timer_clk_en), .hfo_enable(hfo_enable),
   .pll_enable(pll_enable), .pll_mode(pll_mode), .cpu_run(cpu_run),
   .fast_periph_clk_on(fast_periph_clk_on), .other_periph_clk_on(other_periph_clk_on),
   .power_mode(power_mode));

// ### sim/clock_prescaler_power_modes_tb_top.sv
// Directed testbench of the clock prescaler and power mode block
`timescale 1ns/1ns
module clock_prescaler_power_modes_tb_top;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h0;
   logic [31:0] pwdata = 32'h0, prdata;
   logic [3:0] pstrb = 4'hf;
   logic pready, pslverr;
   logic main_tick = 1'b0, pll_tick = 1'b0, lfo_tick = 1'b0, hfo_stable = 1'b1;
   logic wait_exec = 1'b0, interrupt_req = 1'b0, wakeup_event = 1'b0;
   logic sys_clk_en, slow_clk_en, timer_clk_en, aux1_clk_en, aux2_clk_en;
   logic hfo_enable, pll_enable, cpu_run, fast_on, other_on, rng_on;
   logic [2:0] pll_mode;
   logic [1:0] power_mode;
   logic [15:0] cyc = 16'h0;
   logic [15:0] gap [4] = '{default: 16'h0};
   logic [15:0] cnt [4] = '{default: 16'h0};
   int n_errors = 0, n_tests = 0;
   wire [3:0] en = {aux2_clk_en, aux1_clk_en, slow_clk_en, sys_clk_en};

   clock_prescaler_power_modes dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .programming_mode(1'b0),
      .main_tick(main_tick), .pll_tick(pll_tick), .pll_locked(1'b1), .lfo_tick(lfo_tick),
      .lfo_running(1'b1), .hfo_stable(hfo_stable), .wait_exec(wait_exec),
      .interrupt_req(interrupt_req), .wakeup_event(wakeup_event), .sys_clk_en(sys_clk_en),
      .slow_clk_en(slow_clk_en), .timer_clk_en(timer_clk_en), .aux1_clk_en(aux1_clk_en),
      .aux2_clk_en(aux2_clk_en), .hfo_enable(hfo_enable), .pll_enable(pll_enable),
      .pll_mode(pll_mode), .cpu_run(cpu_run), .fast_periph_clk_on(fast_on),
      .other_periph_clk_on(other_on), .rng_osc_enable(rng_on), .power_mode(power_mode));

   always #2 pclk = ~pclk;

   // Main ticks every second cycle so divided periods are easy to tell apart
   always @(posedge pclk) begin
      cyc <= cyc + 16'h1;
      main_tick <= cyc[0];
      pll_tick <= 1'b1;
      lfo_tick <= (cyc[2:0] == 3'h0);
      for (int i = 0; i < 4; i++) begin
         if (en[i]) begin
            gap[i] <= cnt[i] + 16'h1;
            cnt[i] <= 16'h0;
         end else begin
            cnt[i] <= cnt[i] + 16'h1;
         end
      end
   end

   task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
            output logic e);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) n_errors++;
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask

   task rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk(nm, r, exp);
   endtask

   task pulse_wait();
      @(posedge pclk) wait_exec <= 1'b1;
      @(posedge pclk) wait_exec <= 1'b0;
      repeat (3) @(posedge pclk);
   endtask

   task pulse_wake();
      @(posedge pclk) wakeup_event <= 1'b1;
      @(posedge pclk) wakeup_event <= 1'b0;
      repeat (3) @(posedge pclk);
   endtask

   task t_reset();
      logic [31:0] r;
      logic e;
      rd(8'h00, 32'h4f, "sysdiv");
      rd(8'h04, 32'hb6, "slowdiv");
      rd(8'h08, 32'hff, "auxdiv");
      rd(8'h0c, 32'h06, "clkctrl");
      rd(8'h10, 32'h00, "pwrctrl");
      rd(8'h14, 32'h28, "status");
      chk("pll_mode", pll_mode, 32'h4);
      chk("mode", power_mode, 32'h0);
      apb(1'b0, 8'h20, 32'h0, r, e);
      chk("unmapped err", e, 32'h1);
      chk("unmapped data", r, 32'h0);
      $display("test reset done");
   endtask

   task t_dividers();
      wr(8'h00, 32'h42);
      wr(8'h04, 32'h02);
      wr(8'h08, 32'h31);
      wr(8'h0c, 32'h1e);
      // The slow divider first ends its reset-time period of about 730 cycles
      repeat (800) @(posedge pclk);
      chk("sys gap", gap[0], 32'd6);
      chk("slow gap", gap[1], 32'd12);
      chk("aux1 gap", gap[2], 32'd4);
      chk("aux2 gap", gap[3], 32'd8);
      // Power the PLL first; the source switch is refused while it is down
      wr(8'h0c, 32'h1a);
      wr(8'h0c, 32'h18);
      repeat (100) @(posedge pclk);
      chk("pll on", pll_enable, 32'h1);
      chk("pll sys gap", gap[0], 32'd3);
      wr(8'h0c, 32'h1e);
      repeat (100) @(posedge pclk);
      chk("main sys gap", gap[0], 32'd6);
      wr(8'h0c, 32'h3e);
      repeat (2) @(posedge pclk);
      chk("rng", rng_on, 32'h1);
      $display("test dividers done");
   endtask

   task t_pll();
      logic [2:0] m [3] = '{3'h3, 3'h5, 3'h4};
      for (int i = 0; i < 3; i++) begin
         // System clock runs from the main clock here, never from the PLL
         wr(8'h00, {25'h0, m[i], 4'h2});
         repeat (2) @(posedge pclk);
         chk("pll_mode", pll_mode, {29'h0, m[i]});
      end
      wr(8'h00, 32'h62);
      rd(8'h14, 32'h20, "reserved mode");
      wr(8'h00, 32'h42);
      $display("test pll done");
   endtask

   task t_wait();
      pulse_wait();
      chk("stalled", cpu_run, 32'h0);
      @(posedge pclk) interrupt_req <= 1'b1;
      @(posedge pclk) interrupt_req <= 1'b0;
      repeat (3) @(posedge pclk);
      chk("resumed", cpu_run, 32'h1);
      $display("test wait done");
   endtask

   task t_modes();
      wr(8'h10, 32'h01);
      repeat (100) @(posedge pclk);
      chk("ps mode", power_mode, 32'h1);
      chk("ps sys", gap[0], 32'd12);
      pulse_wake();
      chk("ps exit", power_mode, 32'h0);
      wr(8'h10, 32'h0a);
      chk("idle held", power_mode, 32'h0);
      pulse_wait();
      chk("idle mode", power_mode, 32'h2);
      chk("idle fast", fast_on, 32'h1);
      chk("idle other", other_on, 32'h0);
      pulse_wake();
      chk("idle exit", power_mode, 32'h0);
      hfo_stable <= 1'b0;
      wr(8'h10, 32'h0c);
      pulse_wait();
      repeat (20) @(posedge pclk);
      chk("halt mode", power_mode, 32'h3);
      chk("halt osc", hfo_enable, 32'h0);
      chk("halt fast", fast_on, 32'h0);
      pulse_wake();
      chk("halt wait osc", power_mode, 32'h3);
      chk("halt osc restart", hfo_enable, 32'h1);
      hfo_stable <= 1'b1;
      repeat (4) @(posedge pclk);
      chk("halt exit", power_mode, 32'h0);
      rd(8'h10, 32'h08, "halt bit cleared");
      // Slow clock on the LFO lets the oscillator drop in Power Save
      wr(8'h0c, 32'h3f);
      wr(8'h10, 32'h11);
      repeat (40) @(posedge pclk);
      chk("lfo ps sys", gap[0], 32'd8);
      chk("lfo ps osc", hfo_enable, 32'h0);
      pulse_wake();
      chk("lfo ps exit", power_mode, 32'h0);
      chk("lfo active osc", hfo_enable, 32'h1);
      $display("test modes done");
   endtask

   task report_and_stop();
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge pclk);
      n_errors++;
      report_and_stop();
   end

   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      t_reset();
      t_dividers();
      t_pll();
      t_wait();
      t_modes();
      report_and_stop();
   end
endmodule
